// ---- design/addr_check_consts.vh ----
// constants for the address channel character checker
// assumes inclusion by bare name from design files
`ifndef ADDR_CHECK_CONSTS_VH
`define ADDR_CHECK_CONSTS_VH
`define CHAR_W            8
`define CLK_PERIOD_NS     100
`define LONG_CYCLE_NS     4500
`define LONG_CYCLE_ALT_NS 4000
`define LONG_CYCLE_CYC    ((`LONG_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LONG_CYCLE_ALT_CYC ((`LONG_CYCLE_ALT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ZERO_CHAR         8'h00
`define ZERO_PAR_BIT      7
`endif

// ---- design/char_checker.v ----
// two-group character decoder for one channel
// assumes char_i is stable in the cycle it is presented; purely combinational
`timescale 1ns/1ps
`include "addr_check_consts.vh"
module char_checker #(
  parameter W = `CHAR_W
) (
  input  wire [W-1:0] char_i,
  input  wire         force_both_i,
  output wire         grp_odd_o,
  output wire         grp_even_o
);
  // odd group: odd bit count is valid; even group from complement bits
  // a dropped bit lowers odd group; at 8 bits even group rises only under force_both_i, so unforced surplus leaves both down
  wire [W-1:0] char_n = ~char_i;
  wire         any    = |char_i;
  assign grp_odd_o  = (^char_i) | force_both_i;
  assign grp_even_o = ((^char_n) & any & ~(^char_i)) | force_both_i;
endmodule

// ---- design/address_channel_char_checker.v ----
// inbound address channel and exit channel character checking
// assumes cycle_start_i, logic_gate_i, err_sample_i and both valids come from logic on clk_i
// assumes the three test switches are asynchronous panel levels
// Summary of operation
// - two separate checkers, inbound address channel and exit channel
// - valid character raises exactly one of two groups
// - dropped bit raises neither group, surplus bit raises neither too
// - error trigger sets when both groups are up or both down
// - exit trigger at end-of-cycle sample flags exit fault and stops processor
// - exit checker gets a valid character every storage cycle
// - idle exit channel carries inserted zero character
// - first test forces both groups active
// - second test suppresses inserted zero on both channels
// - third test sets error trigger directly
// - inbound errors held until end-of-cycle sample
// - inbound groups sampled after character arrives and decodes, or in a long cycle or second test
// - inbound trigger sticks and raises inbound fault at end of cycle
// - long storage cycle inserts zero onto inbound channel
`timescale 1ns/1ps
`include "addr_check_consts.vh"
module address_channel_char_checker #(
  parameter W         = `CHAR_W,
  parameter LONG_CYC  = `LONG_CYCLE_CYC
) (
  // clock, reset and cycle strobes
  input  wire         clk_i,
  input  wire         reset_n_i,
  input  wire         cycle_start_i,
  input  wire         err_sample_i,
  input  wire         logic_gate_i,

  // inbound and exit channels
  input  wire [W-1:0] in_char_i,
  input  wire         in_valid_i,
  input  wire [W-1:0] exit_char_i,
  input  wire         exit_valid_i,

  // panel test switches, asynchronous
  input  wire         test1_i,
  input  wire         test2_i,
  input  wire         test3_i,

  // triggers, faults and stop, all registered
  output reg          in_err_trig_o,
  output reg          exit_err_trig_o,
  output reg          in_fault_o,
  output reg          exit_fault_o,
  output reg          stop_o
);
  // zero code carries one set bit so that it keeps odd parity
  localparam [W-1:0] ZERO_CHAR = {1'b1, {(W-1){1'b0}}};
  // cycle counter width; limits above 255 cycles need more bits
  localparam         CNT_W     = 8;

  // test switches, first and second synchroniser stage
  reg  [2:0]       tst_meta_q;
  reg  [2:0]       tst_q;
  // cycle length count and logic gate delay
  reg  [CNT_W-1:0] cyc_cnt_q;
  reg              gate_d_q;
  // decoded group lines of both checkers
  wire             in_odd;
  wire             in_even;
  wire             ex_odd;
  wire             ex_even;
  // selected characters and their verdicts
  wire             long_cycle;
  wire [W-1:0]     in_char;
  wire [W-1:0]     exit_char;
  wire             in_bad;
  wire             ex_bad;
  wire             in_sample;
  // synchronised test switches by purpose
  wire             test_force;
  wire             test_block;
  wire             test_set;

  // absent character becomes the zero code unless the second test blocks it
  function [W-1:0] pick_char;
    input         use_char;
    input [W-1:0] ch;
    input         block_zero;
    begin
      case ({use_char, block_zero})
        2'b10,
        2'b11:
          pick_char = ch;
        2'b01:
          pick_char = {W{1'b0}};
        default:
          pick_char = ZERO_CHAR;
      endcase
    end
  endfunction

  // both groups up or both down marks the character bad
  // one function for both channels keeps their verdicts identical
  function pair_bad;
    input odd_grp;
    input even_grp;
    begin
      pair_bad = ~(odd_grp ^ even_grp);
    end
  endfunction

  // test switches come from a panel: first stage only feeds the second
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      tst_meta_q <= 3'h0;
    end
    else
    begin
      tst_meta_q <= {test3_i, test2_i, test1_i};
    end
  end

  // only this stage is read by logic
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      tst_q <= 3'h0;
    end
    else
    begin
      tst_q <= tst_meta_q;
    end
  end

  assign test_force = tst_q[0];
  assign test_block = tst_q[1];
  assign test_set   = tst_q[2];

  // cycle length counter; saturates so a stalled cycle keeps the insert
  // restarts at cycle start so every cycle gets its own limit
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      cyc_cnt_q <= {CNT_W{1'b0}};
    end
    else if (cycle_start_i)
    begin
      cyc_cnt_q <= {CNT_W{1'b0}};
    end
    else if (!long_cycle)
    begin
      cyc_cnt_q <= cyc_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  assign long_cycle = (cyc_cnt_q >= LONG_CYC[CNT_W-1:0]);

  // zero insert on idle exit channel
  assign exit_char = pick_char(exit_valid_i, exit_char_i, test_block);

  // long cycle zero on inbound channel
  assign in_char = pick_char(in_valid_i && !long_cycle, in_char_i, test_block);

  // first test forces both groups
  // inbound decode
  char_checker #(
    .W            (W)
  ) u_in_chk (
    .char_i       (in_char),
    .force_both_i (test_force),
    .grp_odd_o    (in_odd),
    .grp_even_o   (in_even)
  );

  // exit decode
  char_checker #(
    .W            (W)
  ) u_exit_chk (
    .char_i       (exit_char),
    .force_both_i (test_force),
    .grp_odd_o    (ex_odd),
    .grp_even_o   (ex_even)
  );

  // both or neither flags the character
  assign in_bad = pair_bad(in_odd, in_even);
  assign ex_bad = pair_bad(ex_odd, ex_even);

  // sample a gate one clock after it, once decoded
  // one clock lets the character settle through the decode
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      gate_d_q <= 1'b0;
    end
    else
    begin
      gate_d_q <= logic_gate_i;
    end
  end

  // long cycle and second test sample without a gate, as nothing else arrives
  assign in_sample = gate_d_q | long_cycle | test_block;

  // clear at cycle start, set wins
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      in_err_trig_o <= 1'b0;
    end
    else if ((in_sample && in_bad) || test_set)
    begin
      in_err_trig_o <= 1'b1;
    end
    else if (cycle_start_i)
    begin
      in_err_trig_o <= 1'b0;
    end
    // a later good character must not clear a held error
    else
    begin
      in_err_trig_o <= in_err_trig_o;
    end
  end

  // exit trigger on both or neither
  // exit clear at cycle start, set wins
  // exit channel has no gate: every clock is a sample
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      exit_err_trig_o <= 1'b0;
    end
    else if (ex_bad || test_set)
    begin
      exit_err_trig_o <= 1'b1;
    end
    else if (cycle_start_i)
    begin
      exit_err_trig_o <= 1'b0;
    end
    // hold between cycle start and the next error
    else
    begin
      exit_err_trig_o <= exit_err_trig_o;
    end
  end

  // the sample only sets faults; only reset clears them
  // inbound fault at end of cycle
  // faults stay until reset so the indicators can be read after the halt
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      in_fault_o <= 1'b0;
    end
    else if (err_sample_i && in_err_trig_o)
    begin
      in_fault_o <= 1'b1;
    end
  end

  // exit fault at end of cycle
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      exit_fault_o <= 1'b0;
    end
    else if (err_sample_i && exit_err_trig_o)
    begin
      exit_fault_o <= 1'b1;
    end
  end

  // stop on either trigger at the sample
  // one cycle then halt with indicators lit
  // halt is taken at the sample, not at the trigger, so the cycle finishes
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      stop_o <= 1'b0;
    end
    else if (err_sample_i && (in_err_trig_o || exit_err_trig_o))
    begin
      stop_o <= 1'b1;
    end
  end
endmodule

// ---- bench/addr_src.sv ----
`timescale 1ns/1ps
// model of the address registers feeding both channels
// assumes kind 0 good, 1 dropped bit, 2 surplus bit
module addr_src (
  input  wire [1:0] in_kind_i,
  input  wire [1:0] exit_kind_i,
  output wire [7:0] in_char_o,
  output wire [7:0] exit_char_o
);
  // damaged only while the bench asks
  assign in_char_o   = in_kind_i[0] ? 8'h03 : in_kind_i[1] ? 8'h0f : 8'h07;
  assign exit_char_o = exit_kind_i[0] ? 8'h03 : exit_kind_i[1] ? 8'h0f : 8'h07;
endmodule

// ---- bench/addr_check_monitor.sv ----
`timescale 1ns/1ps
// assertions on the checker top ports
// assumes one clock, bound below
module addr_check_monitor #(parameter W = 8, LONG_CYC = 45) (
  input wire clk_i, reset_n_i, cycle_start_i, err_sample_i, logic_gate_i, in_valid_i, exit_valid_i,
  input wire [W-1:0] in_char_i, exit_char_i,
  input wire test1_i, test2_i, test3_i, in_err_trig_o, exit_err_trig_o, in_fault_o, exit_fault_o, stop_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  a_exit_bad_char: assert property (exit_valid_i && !(^exit_char_i) |=> exit_err_trig_o)
    else $error("exit trig");
  a_exit_fault_stop: assert property (err_sample_i && exit_err_trig_o |=> exit_fault_o && stop_o)
    else $error("exit fault");
  a_in_bad_char: assert property (logic_gate_i ##1 (in_valid_i && !(^in_char_i)) |=> in_err_trig_o)
    else $error("in trig");
  a_in_trig_sticks: assert property (in_err_trig_o && !cycle_start_i |=> in_err_trig_o)
    else $error("in sticky");
  a_in_fault_stop: assert property (err_sample_i && in_err_trig_o |=> in_fault_o && stop_o)
    else $error("in fault");
  a_stop_has_cause: assert property (stop_o |-> in_fault_o || exit_fault_o)
    else $error("stop cause");
  a_idle_zero_ok: assert property ((!test1_i && !test2_i && !test3_i)[*3] ##0
    (!exit_valid_i && !exit_err_trig_o) |=> !exit_err_trig_o)
    else $error("zero insert");
  a_test3_sets: assert property (test3_i[*3] |=> in_err_trig_o && exit_err_trig_o)
    else $error("test3");
endmodule
bind address_channel_char_checker addr_check_monitor #(.W(W), .LONG_CYC(LONG_CYC)) u_addr_check_monitor (.*);

// ---- bench/address_channel_char_checker_tb.sv ----
`timescale 1ns/1ps
// bench for the address channel checker
// assumes model and monitor compiled first
module address_channel_char_checker_tb;
  logic clk_i = 0, reset_n_i = 0, cycle_start_i = 0, err_sample_i = 0, logic_gate_i = 0;
  logic in_valid_i = 0, exit_valid_i = 0, test1_i = 0, test2_i = 0, test3_i = 0;
  logic [1:0] ik = 0, ek = 0;
  wire [7:0] in_char_i, exit_char_i;
  wire in_err_trig_o, exit_err_trig_o, in_fault_o, exit_fault_o, stop_o;
  int error_cnt = 0, checked = 0;
  addr_src u_addr_src (.in_kind_i(ik), .exit_kind_i(ek), .in_char_o(in_char_i), .exit_char_o(exit_char_i));
  // short long-cycle limit keeps the run brief
  address_channel_char_checker #(.LONG_CYC(8)) u_address_channel_char_checker (.*);
  initial forever #50 clk_i = ~clk_i;
  task automatic chk(input string n, input logic s, e);
    checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("ERROR %s exp %b seen %b", n, e, s);
    end
  endtask
  task automatic ck(int n); repeat (n) @(posedge clk_i); endtask
  task automatic rst; @(posedge clk_i); reset_n_i <= 0; {ik, ek, in_valid_i, exit_valid_i} <= 0; ck(3); reset_n_i <= 1; endtask
  task automatic smp; ck(1); err_sample_i <= 1; ck(1); err_sample_i <= 0; @(negedge clk_i); endtask
  task automatic t_exit;
    rst; exit_valid_i <= 1; ek <= 2; ck(1); exit_valid_i <= 0; @(negedge clk_i);
    chk("exit_trig", exit_err_trig_o, 1);
    chk("stop_early", stop_o, 0);
    smp; chk("exit_fault", exit_fault_o, 1);
  endtask
  task automatic t_in;
    rst; cycle_start_i <= 1; ck(1); cycle_start_i <= 0; in_valid_i <= 1; ik <= 1; logic_gate_i <= 1;
    ck(1); logic_gate_i <= 0; ck(1); ik <= 0; logic_gate_i <= 1; ck(1); logic_gate_i <= 0; ck(2);
    @(negedge clk_i); chk("in_trig", in_err_trig_o, 1);
    chk("in_early", in_fault_o, 0);
    smp; chk("in_fault", in_fault_o, 1);
  endtask
  task automatic t_long;
    // a bad char left standing must be replaced by the zero once the cycle runs long
    rst; in_valid_i <= 1; ik <= 1; cycle_start_i <= 1; ck(1); cycle_start_i <= 0; ck(12); @(negedge clk_i);
    chk("in_idle", in_err_trig_o, 0);
    chk("exit_idle", exit_err_trig_o, 0);
    ck(1); test2_i <= 1; ck(4); test2_i <= 0; @(negedge clk_i);
    chk("in_t2", in_err_trig_o, 1);
    chk("exit_t2", exit_err_trig_o, 1);
  endtask
  task automatic t_test;
    for (int i = 0; i < 3; i++)
    begin
      rst; {test3_i, test2_i, test1_i} <= 3'h1 << i; cycle_start_i <= 1; ck(1); cycle_start_i <= 0; ck(2);
      logic_gate_i <= 1; ck(1); logic_gate_i <= 0; ck(2); {test3_i, test2_i, test1_i} <= 0; smp;
      chk("in_flt", in_fault_o, 1);
      chk("exit_flt", exit_fault_o, 1);
    end
  endtask
  task automatic test_done;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    t_exit; t_in; t_long; t_test; test_done;
  end
  initial
  begin
    #100000; error_cnt++; test_done;
  end
endmodule
